// [hw/tx_ctrl_pkg.sv]
/*
 * Shared constants for the transmit state sequencer: timing, stop choices,
 * two-wire port command words and the state type.
 * Assumes the core clock runs at 25 MHz.
 */
package tx_ctrl_pkg;
    localparam int CLK_KHZ = 25000;
    localparam int OSC_SETTLE_US = 400;
    localparam int TUNE_US = 370;
    localparam int STOP_MAX_MS = 90;
    // Derived cycle counts; typical figures, so no rounding direction matters
    localparam int OSC_SETTLE_CYCLES = OSC_SETTLE_US * CLK_KHZ / 1000;
    localparam int TUNE_CYCLES = TUNE_US * CLK_KHZ / 1000;
    localparam int MS_CYCLES = CLK_KHZ;
    localparam int TIMER_W = 16;
    // Stop selection: codes 0..7 give 2..9 ms, codes 8..15 give 20..90 ms
    localparam int STOP_SEL_W = 4;
    localparam logic [6:0] STOP_SHORT_BASE_MS = 7'h02;
    localparam logic [6:0] STOP_LONG_STEP_MS = 7'h0a;
    localparam logic [6:0] STOP_LONG_BASE_MS = 7'h14;
    // Two-wire port commands, shifted most significant bit first
    localparam int PORT_RESET_LEN = 48;
    localparam logic [47:0] PORT_RESET_WORD = 48'h0000_0000_8d00;
    localparam logic [15:0] PORT_DISABLE_WORD = 16'h8d02;
    localparam logic [15:0] SOFT_RESET_WORD = 16'hbd01;
    // Sample FIFO shape
    localparam int FIFO_WIDTH = 1;
    localparam int FIFO_DEPTH = 8;
    typedef enum logic [1:0] {
        ST_SLEEP,
        ST_OSC_STARTUP,
        ST_TUNE,
        ST_TRANSMIT
    } tx_state_type;
endpackage

// [hw/sample_fifo_if.sv]
/*
 * Valid/ready bundle between the sequencer and its sample FIFO.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
interface sample_fifo_if #(parameter int WIDTH = 1);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
    modport fifo_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface
`default_nettype wire

// [hw/sample_fifo.sv]
/*
 * Small synchronous FIFO, width and depth as parameters.
 * Assumes one clock and a synchronous active-high reset; depth a power of two.
 */
`timescale 1ns/1ns
`default_nettype none
module sample_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Flush request, drops all held words
    input wire logic flush,
    // Data path
    sample_fifo_if.fifo_side port
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = port.in_valid && port.in_ready;
    wire pop = port.out_valid && port.out_ready;

    ////////////////////////////////////////////////////////////////////////
    // Flags come from the count, so full and empty are exact
    assign port.in_ready = (count != (AW+1)'(DEPTH));
    assign port.out_valid = (count != '0);
    assign port.out_data = mem[rd_ptr];

    // Storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= port.in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge core_clk) begin
        if (rst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// [hw/tx_state_control.sv]
/*
 * Transmit state sequencer: sleep, oscillator startup, tune, transmit,
 * start-edge detection, stop-on-low timing and the two-wire command port.
 * Assumes data_pin and port_clk arrive from a host outside this clock domain.
 */
// What this block does
// - Four states, walked sleep, oscillator startup, tune, transmit in order.
// - Sleep keeps oscillator, synthesizer and amplifier all off.
// - Configured rising or falling data edge leaves sleep and starts the oscillator.
// - Tune lasts about 370 us, then transmit follows.
// - Amplifier stays off and data is dropped until transmit begins.
// - In transmit the data pin level is continuously fed to the modulator.
// - Data low continuously for the stop time ends the transmission.
// - Stop time is 2 to 9 ms by 1 ms or 20 to 90 ms by 10.
// - Soft reset command during transmit ends it within 1 ms.
// - Falling-edge mode: move to tune once settled, ignore data in tune.
// - Port is data plus clock, host clock between 10 kHz and 1 MHz.
// - Port reset: 32 low clocks then 0x8d00, 48 clocks, port logic only.
// - After port reset, start edges are ignored until port disable.
// - Port disable 0x8d02 over 16 clocks re-enables start-edge detection.
// - Soft reset 0xbd01 resets all but the port and returns to sleep.
`timescale 1ns/1ns
`default_nettype none
module tx_state_control
    import tx_ctrl_pkg::*;
#(
    parameter int OSC_CYCLES = tx_ctrl_pkg::OSC_SETTLE_CYCLES,
    parameter int TUNE_CNT = tx_ctrl_pkg::TUNE_CYCLES,
    parameter int MS_CNT = tx_ctrl_pkg::MS_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Host pins
    input wire logic data_pin,
    input wire logic port_clk,
    // Configuration
    input wire logic start_on_falling,
    input wire logic [tx_ctrl_pkg::STOP_SEL_W-1:0] stop_sel,
    // Modulator side
    input wire logic mod_ready,
    output logic mod_valid,
    output logic mod_data,
    output logic sample_accept,
    // Analog enables and status
    output logic crystal_osc_enable,
    output logic synth_enable,
    output logic power_amp_enable,
    output logic port_active,
    output tx_ctrl_pkg::tx_state_type state
);
    import tx_ctrl_pkg::*;

    // Stop time in milliseconds from the selection code
    function automatic logic [6:0] stop_ms(input logic [STOP_SEL_W-1:0] sel);
        logic [6:0] low;
        low = {4'h0, sel[2:0]};
        if (sel[3]) begin
            stop_ms = 7'(STOP_LONG_BASE_MS + 7'(low * STOP_LONG_STEP_MS));
        end else begin
            stop_ms = STOP_SHORT_BASE_MS + low;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second and third stages feed logic
    logic data_meta, data_sync, data_prev;
    logic clk_meta, clk_sync, clk_prev;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_meta <= 1'b0;
            data_sync <= 1'b0;
            data_prev <= 1'b0;
            clk_meta <= 1'b0;
            clk_sync <= 1'b0;
            clk_prev <= 1'b0;
        end else begin
            data_meta <= data_pin;
            data_sync <= data_meta;
            data_prev <= data_sync;
            clk_meta <= port_clk;
            clk_sync <= clk_meta;
            clk_prev <= clk_sync;
        end
    end

    wire data_rise = data_sync && !data_prev;
    wire data_fall = !data_sync && data_prev;
    wire port_clk_rise = clk_sync && !clk_prev;
    // The data pin doubles as port data, so edges only count while the port is off
    wire start_edge = !port_active && (start_on_falling ? data_fall : data_rise);

    ////////////////////////////////////////////////////////////////////////
    // Two-wire command shifter, sampled on the port clock rising edge
    logic [PORT_RESET_LEN-1:0] shift;
    wire [PORT_RESET_LEN-1:0] next_shift = {shift[PORT_RESET_LEN-2:0], data_sync};
    wire hit_port_reset = port_clk_rise && (next_shift == PORT_RESET_WORD);
    wire hit_port_disable = port_clk_rise && port_active && (next_shift[15:0] == PORT_DISABLE_WORD);
    wire hit_soft_reset = port_clk_rise && port_active && (next_shift[15:0] == SOFT_RESET_WORD);

    // A matched command clears the shifter so its bits cannot match twice
    always_ff @(posedge core_clk) begin
        if (rst || hit_port_reset || hit_port_disable || hit_soft_reset) begin
            shift <= '0;
        end else if (port_clk_rise) begin
            shift <= next_shift;
        end
    end

    // Port enable flag; port reset touches nothing else
    always_ff @(posedge core_clk) begin
        if (rst) begin
            port_active <= 1'b0;
        end else if (hit_port_reset) begin
            port_active <= 1'b1;
        end else if (hit_port_disable) begin
            port_active <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Millisecond divider that restarts whenever data goes high, so the stop
    // count measures an unbroken low stretch exactly
    logic [TIMER_W-1:0] ms_div;
    logic [6:0] low_ms;
    wire ms_tick = (ms_div == TIMER_W'(MS_CNT - 1));
    wire counting_low = (state == ST_TRANSMIT) && !data_sync;
    wire stop_reached = counting_low && ms_tick && (low_ms + 7'h01 == stop_ms(stop_sel));

    always_ff @(posedge core_clk) begin
        if (rst || !counting_low) begin
            ms_div <= '0;
            low_ms <= '0;
        end else if (ms_tick) begin
            ms_div <= '0;
            low_ms <= low_ms + 7'h01;
        end else begin
            ms_div <= ms_div + TIMER_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State sequencer
    logic [TIMER_W-1:0] phase_cnt;
    tx_state_type next_state;
    wire osc_done = (phase_cnt == TIMER_W'(OSC_CYCLES - 1));
    wire tune_done = (phase_cnt == TIMER_W'(TUNE_CNT - 1));

    // Next state; data level is not looked at in startup or tune
    always_comb begin
        next_state = state;
        unique case (state)
            ST_SLEEP: if (start_edge) next_state = ST_OSC_STARTUP;
            ST_OSC_STARTUP: if (osc_done) next_state = ST_TUNE;
            ST_TUNE: if (tune_done) next_state = ST_TRANSMIT;
            ST_TRANSMIT: if (stop_reached) next_state = ST_SLEEP;
        endcase
        if (hit_soft_reset) begin
            next_state = ST_SLEEP;
        end
    end

    // State register and phase timer
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state <= ST_SLEEP;
            phase_cnt <= '0;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                phase_cnt <= '0;
            end else begin
                phase_cnt <= phase_cnt + TIMER_W'(1);
            end
        end
    end

    // Analog enables follow the next state so they change with it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            crystal_osc_enable <= 1'b0;
            synth_enable <= 1'b0;
            power_amp_enable <= 1'b0;
        end else begin
            crystal_osc_enable <= (next_state != ST_SLEEP);
            synth_enable <= (next_state == ST_TUNE) || (next_state == ST_TRANSMIT);
            power_amp_enable <= (next_state == ST_TRANSMIT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample path: one data sample per clock into the FIFO, only in transmit
    sample_fifo_if #(.WIDTH(FIFO_WIDTH)) fifo_bus ();
    wire leaving = (state == ST_TRANSMIT) && (next_state != ST_TRANSMIT);

    assign fifo_bus.in_valid = (state == ST_TRANSMIT);
    assign fifo_bus.in_data = data_sync;
    // Output stage accepts a word when empty or when the modulator takes one
    assign fifo_bus.out_ready = !mod_valid || mod_ready;

    sample_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) fifo_inst (
        .core_clk(core_clk),
        .rst(rst),
        .flush(leaving),
        .port(fifo_bus.fifo_side)
    );

    // Registered output stage; a stalled modulator backs up into the FIFO and
    // samples taken while it is full are lost, shown by sample_accept low
    always_ff @(posedge core_clk) begin
        if (rst || leaving) begin
            mod_valid <= 1'b0;
            mod_data <= 1'b0;
            sample_accept <= 1'b0;
        end else begin
            sample_accept <= fifo_bus.in_ready && fifo_bus.in_valid;
            if (fifo_bus.out_ready) begin
                mod_valid <= fifo_bus.out_valid;
                mod_data <= fifo_bus.out_data[0];
            end
        end
    end
endmodule
`default_nettype wire

// [sim/tx_state_control_sva.sv]
/* Port checker for the transmit sequencer.
   Assumes binding to tx_state_control with the same parameters. */
`timescale 1ns/1ns
`default_nettype none
module tx_state_control_sva
    import tx_ctrl_pkg::*;
#(parameter int OSC_CYCLES = 20, parameter int TUNE_CNT = 15, parameter int MS_CNT = 50) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Watched ports
    input wire logic data_pin,
    input wire logic port_clk,
    input wire logic start_on_falling,
    input wire logic [tx_ctrl_pkg::STOP_SEL_W-1:0] stop_sel,
    input wire logic mod_ready,
    input wire logic mod_valid,
    input wire logic mod_data,
    input wire logic sample_accept,
    input wire logic crystal_osc_enable,
    input wire logic synth_enable,
    input wire logic power_amp_enable,
    input wire logic port_active,
    input wire tx_ctrl_pkg::tx_state_type state
);
    int low_cnt;
    int stop_cyc;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Stop time in cycles for the selected code
    assign stop_cyc = (stop_sel < 8) ? (int'(stop_sel) + 2) * MS_CNT : (int'(stop_sel) - 6) * 10 * MS_CNT;
    // Raw low run inside transmit; the pin synchronizer only makes the device later
    always_ff @(posedge core_clk) begin
        low_cnt <= (rst || state != ST_TRANSMIT || data_pin) ? 0 : low_cnt + 1;
    end
    sequence enter_osc;
        state == ST_OSC_STARTUP && $past(state) == ST_SLEEP;
    endsequence
    sequence enter_tune;
        state == ST_TUNE && $past(state) == ST_OSC_STARTUP;
    endsequence
    state_order_a: assert property (state != $past(state) |-> state == ST_SLEEP || 2'(state) == 2'($past(state)) + 2'h1)
        else $error("state skipped");
    osc_enable_a: assert property (crystal_osc_enable == (state != ST_SLEEP))
        else $error("oscillator enable wrong");
    synth_enable_a: assert property (synth_enable == (state inside {ST_TUNE, ST_TRANSMIT}))
        else $error("synthesizer enable wrong");
    amp_enable_a: assert property (power_amp_enable == (state == ST_TRANSMIT))
        else $error("amplifier enable wrong");
    osc_len_a: assert property (enter_osc |-> ##OSC_CYCLES state == ST_TUNE)
        else $error("startup length wrong");
    tune_len_a: assert property (enter_tune |-> ##TUNE_CNT state == ST_TRANSMIT)
        else $error("tune length wrong");
    stop_bound_a: assert property (state == ST_TRANSMIT |-> low_cnt <= stop_cyc + 3)
        else $error("stop came late");
    port_block_a: assert property (state == ST_SLEEP && port_active |=> state == ST_SLEEP)
        else $error("start while port active");
    mod_idle_a: assert property (mod_valid |-> state == ST_TRANSMIT)
        else $error("sample outside transmit");
    mod_hold_a: assert property (mod_valid && !mod_ready && state == ST_TRANSMIT |=>
        state != ST_TRANSMIT || (mod_valid && $stable(mod_data)))
        else $error("sample not held");
endmodule
`default_nettype wire

// [sim/host_model.sv]
/* Host model driving the data pin and the two-wire port clock.
   Assumes the core clock for pacing; every change lands on its falling edge. */
`timescale 1ns/1ns
`default_nettype none
module host_model (
    // Pacing clock
    input wire logic core_clk,
    // Host pins
    output logic data_pin,
    output logic port_clk
);
    localparam int HALF = 13; // 520 ns high and 560 ns low (with the data step) keep the port clock just under 1 MHz
    initial begin
        data_pin = 1'b0;
        port_clk = 1'b0; // Port clock stands low between commands
    end
    // Data level change
    task automatic set_data(input logic v);
        @(negedge core_clk);
        data_pin = v;
    endtask
    // One port bit; data moves only while the clock is low
    task automatic clock_bit(input logic b);
        set_data(b);
        repeat (HALF) @(negedge core_clk);
        port_clk = 1'b1;
        repeat (HALF) @(negedge core_clk);
        port_clk = 1'b0;
    endtask
    // Commands, most significant bit first
    task automatic send48(input logic [47:0] w);
        for (int i = 47; i >= 0; i--) clock_bit(w[i]);
    endtask
    task automatic send16(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) clock_bit(w[i]);
    endtask
endmodule
`default_nettype wire

// [sim/tx_state_control_bench.sv]
/* Bench: port commands, then a full cycle for every stop code, even codes on the rising and odd codes on the falling start edge.
   Assumes host_model and the checker are compiled before this file. */
`timescale 1ns/1ns
`default_nettype none
module tx_state_control_bench;
    import tx_ctrl_pkg::*;
    localparam int OSC = 20;
    localparam int TUN = 15;
    localparam int MS = 50;
    typedef struct {tx_state_type st; int gap; int tol;} note_type;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic start_on_falling = 1'b0;
    logic [STOP_SEL_W-1:0] stop_sel = 4'hf;
    logic mod_ready = 1'b1;
    logic data_pin, port_clk, mod_valid, mod_data, sample_accept;
    logic crystal_osc_enable, synth_enable, power_amp_enable, port_active;
    tx_state_type state;
    tx_state_type last = ST_SLEEP;
    note_type notes[$];
    note_type nt;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int ref_cyc = 0;
    bit watch = 1'b0;
    always #20 core_clk = ~core_clk;
    host_model host_model_inst (.core_clk(core_clk), .data_pin(data_pin), .port_clk(port_clk));
    tx_state_control #(.OSC_CYCLES(OSC), .TUNE_CNT(TUN), .MS_CNT(MS)) tx_state_control_inst (
        .core_clk(core_clk), .rst(rst), .data_pin(data_pin), .port_clk(port_clk),
        .start_on_falling(start_on_falling), .stop_sel(stop_sel), .mod_ready(mod_ready),
        .mod_valid(mod_valid), .mod_data(mod_data), .sample_accept(sample_accept),
        .crystal_osc_enable(crystal_osc_enable), .synth_enable(synth_enable),
        .power_amp_enable(power_amp_enable), .port_active(port_active), .state(state));
    ////////////////////////////////////////
    task automatic check(input bit ok, input string msg);
        n_compared++;
        if (!ok) begin
            fail_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Bounded wait; the design may never get there
    task automatic wait_state(input tx_state_type s, input int lim);
        for (int i = 0; i < lim && state !== s; i++) @(negedge core_clk);
        check(state === s, "state not reached");
    endtask
    // Cycle counter with a hang ceiling
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc > 60000) begin
            fail_count++;
            final_report();
        end
    end
    // Each state change after watch is set takes the oldest note; gap counts from the last reference
    always @(negedge core_clk) begin
        if (!rst && watch && state !== last) begin
            if (notes.size() > 0) begin
                nt = notes.pop_front();
            end else begin
                nt = '{ST_SLEEP, -9999, 0}; // Unexpected step, the gap test below trips
            end
            check(state === nt.st && cyc - ref_cyc - nt.gap <= nt.tol && ref_cyc + nt.gap - cyc <= nt.tol, "state step");
            ref_cyc = cyc;
        end
        last = state;
    end
    // Whole cycle; odd codes use the falling start edge
    task automatic run_cycle(input int code);
        int stop;
        stop = (code < 8) ? (code + 2) * MS : (code - 6) * 10 * MS;
        stop_sel = 4'(code);
        start_on_falling = code[0];
        host_model_inst.set_data(code[0]);
        repeat (4) @(negedge core_clk);
        notes.push_back('{ST_OSC_STARTUP, 4, 1});
        notes.push_back('{ST_TUNE, OSC, 0});
        notes.push_back('{ST_TRANSMIT, TUN, 0});
        host_model_inst.set_data(!code[0]);
        ref_cyc = cyc;
        wait_state(ST_TRANSMIT, OSC + TUN + 10);
        mod_ready = 1'b0;
        repeat (16) host_model_inst.set_data(1'($urandom));
        check(sample_accept === 1'b0 && mod_valid === 1'b1, "full buffer took a sample");
        mod_ready = 1'b1;
        repeat (16) host_model_inst.set_data(1'($urandom));
        check(sample_accept === 1'b1, "draining buffer refused");
        // A steady level for longer than sync plus FIFO latency must reach the modulator
        host_model_inst.set_data(1'b1);
        repeat (16) @(negedge core_clk);
        check(mod_valid === 1'b1 && mod_data === 1'b1, "high level not carried");
        host_model_inst.set_data(1'b0);
        ref_cyc = cyc;
        notes.push_back('{ST_SLEEP, stop + 2, 1});
        repeat (16) @(negedge core_clk);
        check(mod_valid === 1'b1 && mod_data === 1'b0, "low level not carried");
        wait_state(ST_SLEEP, stop + 10);
    endtask
    // Main sequence
    initial begin
        void'($urandom(32'h83cd));
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        host_model_inst.send48(PORT_RESET_WORD);
        repeat (5) @(negedge core_clk);
        check(port_active === 1'b1 && state === ST_TRANSMIT, "port reset");
        host_model_inst.send16(SOFT_RESET_WORD);
        wait_state(ST_SLEEP, MS);
        check(port_active === 1'b1, "port lost on soft reset");
        host_model_inst.set_data(1'b0);
        host_model_inst.set_data(1'b1);
        repeat (8) @(negedge core_clk);
        check(state === ST_SLEEP, "start while port active");
        host_model_inst.send16(PORT_DISABLE_WORD);
        repeat (5) @(negedge core_clk);
        check(port_active === 1'b0, "port still active");
        watch = 1'b1;
        for (int c = 0; c < 16; c++) run_cycle(c);
        repeat (5) @(negedge core_clk);
        check(notes.size() == 0, "state steps missing");
        final_report();
    end
endmodule
bind tx_state_control tx_state_control_sva #(.OSC_CYCLES(OSC_CYCLES), .TUNE_CNT(TUNE_CNT), .MS_CNT(MS_CNT))
    tx_state_control_sva_inst (.core_clk(core_clk), .rst(rst), .data_pin(data_pin), .port_clk(port_clk),
    .start_on_falling(start_on_falling), .stop_sel(stop_sel), .mod_ready(mod_ready), .mod_valid(mod_valid),
    .mod_data(mod_data), .sample_accept(sample_accept), .crystal_osc_enable(crystal_osc_enable),
    .synth_enable(synth_enable), .power_amp_enable(power_amp_enable), .port_active(port_active), .state(state));
`default_nettype wire
